// ==== include/pdm_pkg.sv ====
package pdm_pkg;

   // ************************************************************
   // bus shape
   // ************************************************************
   localparam int unsigned APB_ADDR_W = 12;

   // register indices; byte address is four times the index
   localparam logic [31:0] IDX_PRIMARY = 32'h0fffff82;
   localparam logic [31:0] IDX_SECONDARY = 32'hffffff88;
   localparam logic [31:0] IDX_THIRD = 32'hffffff8a;
   localparam logic [31:0] IDX_AUX = 32'hffffff8c;

   // ************************************************************
   // reset values and field positions
   // ************************************************************
   localparam logic [7:0] PRIMARY_RST = 8'h00;
   localparam logic [7:0] SECONDARY_RST = 8'h00;
   localparam logic [7:0] THIRD_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   localparam int unsigned DEEP_HALT_SELECT_BIT = 7;
   localparam int unsigned TIMER_UNIT_STOP_BIT = 2;
   localparam int unsigned CALENDAR_STOP_BIT = 1;
   localparam int unsigned SERIAL_PLAIN_STOP_BIT = 0;
   localparam logic [7:0] PRIMARY_WR_MASK = 8'h87;
   localparam int unsigned DMA_STOP_BIT = 7;
   localparam int unsigned DAC_STOP_BIT = 6;
   localparam int unsigned ADC_STOP_BIT = 5;
   localparam int unsigned DISPLAY_OFF_BIT = 4;
   localparam int unsigned DISPLAY_FETCH_BIT = 3;
   localparam int unsigned CARD_STOP_BIT = 2;
   localparam int unsigned FIFO_SERIAL_STOP_BIT = 1;
   localparam int unsigned INFRARED_STOP_BIT = 0;
   localparam int unsigned BUS_HALT_STOP_BIT = 7;
   localparam int unsigned WATCHDOG_FIXED_BIT = 0;
   localparam logic [7:0] THIRD_WR_MASK = 8'h81;
   localparam int unsigned BUS_QUARTER_BIT = 0;
   localparam logic [7:0] AUX_WR_MASK = 8'h01;
   localparam int unsigned AUX_MODE_LSB = 4;

   // ************************************************************
   // timing counts
   // ************************************************************
   localparam int unsigned WDT_FIXED_DIV = 65536;
   localparam int unsigned BUS_QUARTER_DIV = 4;
   localparam int unsigned MOD_N = 9;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b001,
      MODE_LIGHT = 3'b010,
      MODE_DEEP = 3'b100
   } pdm_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pdm_apb_req_t;

   // msb first: dma, dac, adc, card, fifo serial, infrared, timer, calendar, plain serial
   typedef struct packed {
      logic dma_controller;
      logic dac_block;
      logic adc_block;
      logic card_controller;
      logic serial_with_queue;
      logic infrared_serial;
      logic timer_unit;
      logic calendar_clock;
      logic serial_plain;
   } pdm_mod_en_t;

endpackage

// ==== logic/pdm_clk_div.sv ====
`timescale 1ns/100ps
module pdm_clk_div #(
   parameter int unsigned DIV = 4
) (
   input wire logic clk,     // system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic run,     // divider runs while high
   output logic tick         // one-cycle enable every DIV cycles
);
   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_reg;
   wire wrap = (cnt_reg == LAST);

   // idle divider restarts so the first tick comes a full period after run
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else begin
         cnt_reg <= (!run || wrap) ? '0 : cnt_reg + 1'b1;
         tick <= run && wrap;
      end
   end
endmodule

// ==== logic/pdm_power_ctrl.sv ====
// Implementation choice: register access over APB.
`timescale 1ns/100ps
// Behaviour
// - halt with select 0 enters light halt
// - halt with select 1 enters deep halt
// - primary register resets to zero
// - primary bits six to three read zero
// - primary bit 2 stops timer clock
// - primary bit 1 stops calendar interface clock
// - primary bit 0 stops plain serial clock
// - secondary register resets to zero
// - secondary bit 7 stops dma clock
// - secondary bit 6 stops dac clock
// - secondary bit 5 stops adc clock
// - secondary bit 4 forces display off
// - secondary bit 3 stops display fetch
// - secondary bit 2 stops card controller clock
// - secondary bit 1 stops fifo serial clock
// - secondary bit 0 stops infrared serial clock
// - light halt refresh drives both status low
// - light halt may quarter the bus clock
// - light halt may stop main bus clock
// - stopped timer holds pins, serial resets
// - cpu halts only in halt modes
// - deep halt timer runs on calendar input
// - light halt status high one, low zero
// - deep halt status high zero, low one
// - third bit 7 stops bus clock in light halt
// - third bit 0 fixes watchdog divider
module pdm_power_ctrl
   import pdm_pkg::*;
#(
   parameter int unsigned WDT_DIV = pdm_pkg::WDT_FIXED_DIV,
   parameter int unsigned BUS_DIV = pdm_pkg::BUS_QUARTER_DIV
) (
   input wire logic clk,                       // 10 MHz system clock
   input wire logic sys_rst,                   // async reset, active high
   input wire pdm_pkg::pdm_apb_req_t apb_req,  // apb request group
   output logic [31:0] prdata,                 // apb read data
   output logic pready,                        // apb ready
   output logic pslverr,                       // apb error, unmapped address
   input wire logic halt_exec,                 // cpu executes halt, one cycle
   input wire logic wake_req,                  // interrupt cancels halt
   input wire logic refresh_active,            // memory refresh cycle running
   input wire logic dma_xfer_busy,             // dma transfer in progress
   input wire logic display_xfer_busy,         // display transfer in progress
   input wire logic timer_from_calendar,       // timer counts calendar output
   input wire logic wdt_sel_tick,              // watchdog tick from its own divider
   output pdm_pkg::pdm_mod_en_t mod_clk_en,    // per-module clock enables
   output logic display_off,                   // display forced off
   output logic display_fetch_stop,            // display fetch frozen, zero data
   output logic timer_pins_hold,               // timer pins hold state
   output logic serial_plain_pins_reset,       // plain serial pins at reset state
   output logic cpu_halt,                      // cpu clock stopped
   output logic clock_generator_stop,          // clock generator halted
   output logic self_refresh_req,              // external memory self refresh
   output logic bus_controller_clk_en,         // main bus controller clock
   output logic low_power_bus_controller_clk_en, // low-power bus controller clock
   output logic bus_clk_en,                    // external bus clock enable
   output logic wdt_tick,                      // watchdog count enable
   output logic proc_status_high_pin,          // processing status, upper
   output logic proc_status_low_pin            // processing status, lower
);
   import pdm_pkg::*;

   // ************************************************************
   // registers and state
   // ************************************************************
   logic [7:0] primary_reg;
   logic [7:0] secondary_reg;
   logic [7:0] third_reg;
   logic [7:0] aux_reg;
   pdm_mode_t mode_reg;
   pdm_mode_t mode_next;
   logic [MOD_N-1:0] mod_en_reg;
   logic quarter_tick;
   logic fixed_tick;

   // ************************************************************
   // apb decode
   // ************************************************************
   localparam int unsigned WA = APB_ADDR_W - 2;
   wire [WA-1:0] word_addr = apb_req.paddr[APB_ADDR_W-1:2];
   wire hit_primary = (word_addr == IDX_PRIMARY[WA-1:0]);
   wire hit_secondary = (word_addr == IDX_SECONDARY[WA-1:0]);
   wire hit_third = (word_addr == IDX_THIRD[WA-1:0]);
   wire hit_aux = (word_addr == IDX_AUX[WA-1:0]);
   wire hit_any = hit_primary | hit_secondary | hit_third | hit_aux;
   wire setup_ph = apb_req.psel && !apb_req.penable;
   wire access_done = apb_req.psel && apb_req.penable && pready;
   wire wr_ok = access_done && apb_req.pwrite && hit_any;
   wire [7:0] wdata = apb_req.pwdata[7:0];
   wire [7:0] wr_primary = wdata & PRIMARY_WR_MASK;
   wire [7:0] wr_third = wdata & THIRD_WR_MASK;
   wire [7:0] wr_aux = wdata & AUX_WR_MASK;
   wire [7:0] aux_view = aux_reg | {1'b0, mode_reg, 4'h0};
   wire [7:0] rd_byte = hit_primary ? primary_reg :
                        hit_secondary ? secondary_reg :
                        hit_third ? third_reg :
                        hit_aux ? aux_view : 8'h00;

   // answer is ready in the cycle after setup, so each transfer has no wait
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph && !hit_any;
         prdata <= (setup_ph && !apb_req.pwrite) ? {24'h0, rd_byte} : 32'h0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         primary_reg <= PRIMARY_RST;
         secondary_reg <= SECONDARY_RST;
         third_reg <= THIRD_RST;
         aux_reg <= AUX_RST;
      end else if (wr_ok) begin
         if (hit_primary) primary_reg <= wr_primary;
         if (hit_secondary) secondary_reg <= wdata;
         if (hit_third) third_reg <= wr_third;
         if (hit_aux) aux_reg <= wr_aux;
      end
   end

   // ************************************************************
   // mode machine
   // ************************************************************
   wire deep_sel = primary_reg[DEEP_HALT_SELECT_BIT];
   wire in_light = (mode_reg == MODE_LIGHT);
   wire in_deep = (mode_reg == MODE_DEEP);
   wire in_normal = (mode_reg == MODE_NORMAL);

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_NORMAL: begin
            if (halt_exec) begin
               mode_next = deep_sel ? MODE_DEEP : MODE_LIGHT;
            end
         end
         MODE_LIGHT, MODE_DEEP: begin
            if (wake_req) begin
               mode_next = MODE_NORMAL;
            end
         end
         default: mode_next = MODE_NORMAL;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) mode_reg <= MODE_NORMAL;
      else mode_reg <= mode_next;
   end

   // ************************************************************
   // module clock gating
   // ************************************************************
   wire [MOD_N-1:0] stop_vec = {
      secondary_reg[DMA_STOP_BIT],
      secondary_reg[DAC_STOP_BIT],
      secondary_reg[ADC_STOP_BIT],
      secondary_reg[CARD_STOP_BIT],
      secondary_reg[FIFO_SERIAL_STOP_BIT],
      secondary_reg[INFRARED_STOP_BIT],
      primary_reg[TIMER_UNIT_STOP_BIT],
      primary_reg[CALENDAR_STOP_BIT],
      primary_reg[SERIAL_PLAIN_STOP_BIT]
   };
   // deep halt stops every module except a timer fed from the calendar
   wire [MOD_N-1:0] deep_keep = {6'h00, timer_from_calendar, 2'b00};

   genvar gi;
   generate
      for (gi = 0; gi < MOD_N; gi++) begin : g_gate
         // clearing the stop bit re-enables on the next edge
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) mod_en_reg[gi] <= 1'b1;
            else mod_en_reg[gi] <= !stop_vec[gi] && !(in_deep && !deep_keep[gi]);
         end
      end
   endgenerate

   assign mod_clk_en = pdm_mod_en_t'(mod_en_reg);

   // ************************************************************
   // bus clocking, cpu and pins
   // ************************************************************
   wire bus_halt_stop = third_reg[BUS_HALT_STOP_BIT];
   wire quarter_sel = aux_reg[BUS_QUARTER_BIT];
   wire quarter_run = in_light && quarter_sel;
   wire lp_bus_need = dma_xfer_busy || display_xfer_busy;
   wire wdt_fixed = third_reg[WATCHDOG_FIXED_BIT];

   pdm_clk_div #(.DIV(BUS_DIV)) u_bus_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(quarter_run),
      .tick(quarter_tick)
   );

   pdm_clk_div #(.DIV(WDT_DIV)) u_wdt_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(wdt_fixed),
      .tick(fixed_tick)
   );

   wire status_hi_next = in_light && !refresh_active;
   wire status_lo_next = in_deep;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         proc_status_high_pin <= 1'b1;
         proc_status_low_pin <= 1'b1;
         cpu_halt <= 1'b0;
         clock_generator_stop <= 1'b0;
         self_refresh_req <= 1'b0;
         bus_controller_clk_en <= 1'b1;
         low_power_bus_controller_clk_en <= 1'b1;
         bus_clk_en <= 1'b1;
         wdt_tick <= 1'b0;
         display_off <= 1'b0;
         display_fetch_stop <= 1'b0;
         timer_pins_hold <= 1'b0;
         serial_plain_pins_reset <= 1'b0;
      end else begin
         proc_status_high_pin <= status_hi_next;
         proc_status_low_pin <= status_lo_next;
         cpu_halt <= !in_normal;
         clock_generator_stop <= in_deep;
         self_refresh_req <= in_deep;
         // main bus clock only stops in halt modes, never in normal run
         bus_controller_clk_en <= !in_deep && !(in_light && bus_halt_stop);
         low_power_bus_controller_clk_en <= !in_deep &&
            (!(in_light && bus_halt_stop) || lp_bus_need);
         // refresh timing is counted elsewhere in core clocks, so its rate holds
         bus_clk_en <= in_deep ? 1'b0 : (quarter_run ? quarter_tick : 1'b1);
         wdt_tick <= wdt_fixed ? fixed_tick : wdt_sel_tick;
         display_off <= secondary_reg[DISPLAY_OFF_BIT];
         display_fetch_stop <= secondary_reg[DISPLAY_FETCH_BIT];
         timer_pins_hold <= primary_reg[TIMER_UNIT_STOP_BIT];
         serial_plain_pins_reset <= primary_reg[SERIAL_PLAIN_STOP_BIT];
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_LIGHT_ENTRY: assert property (
      in_normal && halt_exec && !deep_sel |=> in_light ##1 proc_status_high_pin || refresh_active
      || $past(refresh_active) || wake_req || $past(wake_req))
      else $error("light halt not entered");

   AST_DEEP_ENTRY: assert property (
      in_normal && halt_exec && deep_sel |=> in_deep ##1 (cpu_halt && clock_generator_stop
      && self_refresh_req) || $past(wake_req))
      else $error("deep halt not entered");

   AST_PRIMARY_RSVD: assert property (
      setup_ph && !apb_req.pwrite && hit_primary |=> prdata[6:3] == 4'h0 && pready)
      else $error("reserved primary bits read nonzero");

   AST_TIMER_GATE: assert property (
      primary_reg[TIMER_UNIT_STOP_BIT] |=> !mod_clk_en.timer_unit && timer_pins_hold)
      else $error("timer clock not stopped");

   AST_DMA_GATE: assert property (
      $rose(secondary_reg[DMA_STOP_BIT]) |=> !mod_clk_en.dma_controller)
      else $error("dma clock not stopped");

   AST_FETCH_STOP: assert property (
      secondary_reg[DISPLAY_FETCH_BIT] |=> display_fetch_stop)
      else $error("display fetch not stopped");

   AST_REFRESH_PINS: assert property (
      in_light && refresh_active |=> !proc_status_high_pin && !proc_status_low_pin)
      else $error("status pins not low during refresh");

   AST_DEEP_PINS: assert property (
      in_deep |=> !proc_status_high_pin && proc_status_low_pin)
      else $error("deep halt status pins wrong");

   AST_BUS_NORMAL: assert property (
      in_normal |=> bus_controller_clk_en && low_power_bus_controller_clk_en)
      else $error("bus clock stopped in normal mode");

   AST_QUARTER: assert property (
      quarter_run && bus_clk_en ##1 quarter_run [*3] |-> !bus_clk_en && $past(!bus_clk_en))
      else $error("bus clock not divided by four");

   COV_LIGHT: cover property (in_normal && halt_exec && !deep_sel ##1 in_light);
   COV_DEEP: cover property (in_normal && halt_exec && deep_sel ##1 in_deep);
   COV_WAKE: cover property (in_light ##1 wake_req ##1 in_normal);
   COV_WRITE: cover property (wr_ok && hit_secondary);
endmodule

// ==== verification/pdm_cpu_model.sv ====
`timescale 1ns/100ps
module pdm_cpu_model (
   input wire logic clk,          // system clock
   input wire logic sys_rst,      // async reset, active high
   input wire logic halt_go,      // bench asks for a halt instruction
   input wire logic wake_go,      // bench asks for a wake interrupt
   input wire logic refresh_en,   // periodic refresh traffic on
   input wire logic busy_en,      // dma and display traffic on
   output logic halt_exec,        // halt instruction strobe
   output logic wake_req,         // wake interrupt
   output logic refresh_active,   // refresh cycle running
   output logic dma_xfer_busy,    // dma transfer running
   output logic display_xfer_busy, // display transfer running
   output logic wdt_sel_tick      // watchdog tick from its own divider
);
   logic [3:0] cnt_reg;

   // busy patterns overlap on purpose so either source alone must wake the clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 4'h0;
         halt_exec <= 1'b0;
         wake_req <= 1'b0;
         refresh_active <= 1'b0;
         dma_xfer_busy <= 1'b0;
         display_xfer_busy <= 1'b0;
         wdt_sel_tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         halt_exec <= halt_go;
         wake_req <= wake_go;
         refresh_active <= refresh_en && cnt_reg[2:0] == 3'h7;
         dma_xfer_busy <= busy_en && cnt_reg[1];
         display_xfer_busy <= busy_en && cnt_reg[3:2] == 2'h3;
         wdt_sel_tick <= cnt_reg[1:0] == 2'h3;
      end
   end
endmodule

// ==== verification/tb_power_down_module_stop_ctrl.sv ====
`timescale 1ns/100ps
module tb_power_down_module_stop_ctrl;
   import pdm_pkg::*;
   localparam int unsigned WDT_N = 8;
   localparam logic [31:0] A_PRI = IDX_PRIMARY << 2;
   localparam logic [31:0] A_SEC = IDX_SECONDARY << 2;
   localparam logic [31:0] A_THI = IDX_THIRD << 2;
   localparam logic [31:0] A_AUX = IDX_AUX << 2;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   pdm_apb_req_t apb_req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, halt_exec, wake_req, refresh_active, wdt_sel_tick;
   logic dma_xfer_busy, display_xfer_busy;
   logic timer_from_calendar = 1'b0;
   logic halt_go = 1'b0;
   logic wake_go = 1'b0;
   logic refresh_en = 1'b0;
   logic busy_en = 1'b0;
   pdm_mod_en_t mod_clk_en;
   logic display_off, display_fetch_stop, timer_pins_hold, serial_plain_pins_reset;
   logic cpu_halt, clock_generator_stop, self_refresh_req, bus_controller_clk_en;
   logic low_power_bus_controller_clk_en, bus_clk_en, wdt_tick;
   logic proc_status_high_pin, proc_status_low_pin;
   int err_count = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic er;

   pdm_power_ctrl #(.WDT_DIV(WDT_N), .BUS_DIV(4)) i_pdm_power_ctrl (
      .clk, .sys_rst, .apb_req, .prdata, .pready, .pslverr, .halt_exec, .wake_req,
      .refresh_active, .dma_xfer_busy, .display_xfer_busy, .timer_from_calendar,
      .wdt_sel_tick, .mod_clk_en, .display_off, .display_fetch_stop, .timer_pins_hold,
      .serial_plain_pins_reset, .cpu_halt, .clock_generator_stop, .self_refresh_req,
      .bus_controller_clk_en, .low_power_bus_controller_clk_en, .bus_clk_en, .wdt_tick,
      .proc_status_high_pin, .proc_status_low_pin);

   pdm_cpu_model i_pdm_cpu_model (
      .clk, .sys_rst, .halt_go, .wake_go, .refresh_en, .busy_en, .halt_exec, .wake_req,
      .refresh_active, .dma_xfer_busy, .display_xfer_busy, .wdt_sel_tick);

   initial begin
      forever #50 clk = ~clk;
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   // one apb transfer; read data and error taken at the edge pready is seen
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a[11:0], d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers counts as a mismatch
      if (pready !== 1'b1) begin
         err_count++;
         $display("unexpected apb ready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      apb_req <= '0;
   endtask

   task automatic strobe(input bit h);
      @(posedge clk);
      if (h) halt_go <= 1'b1;
      else wake_go <= 1'b1;
      @(posedge clk);
      halt_go <= 1'b0;
      wake_go <= 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic status(input logic hi, input logic lo);
      chk_val("status high", hi, proc_status_high_pin);
      chk_val("status low", lo, proc_status_low_pin);
   endtask

   // pulses of the watchdog tick (sel 0) or bus clock enable (sel 1) in 32 cycles
   task automatic count32(input bit sel, output int n);
      n = 0;
      repeat (32) begin
         @(negedge clk);
         n += sel ? int'(bus_clk_en) : int'(wdt_tick);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs();
      logic [7:0] s;
      apb(1'b1, A_PRI, 32'hff);
      apb(1'b0, A_PRI, 32'h0);
      chk_val("primary readback", 32'h87, rd);
      repeat (2) @(negedge clk);
      chk_val("module enables", 9'h1f8, mod_clk_en);
      chk_val("timer pins hold", 1'b1, timer_pins_hold);
      chk_val("serial pins reset", 1'b1, serial_plain_pins_reset);
      chk_val("cpu halt", 1'b0, cpu_halt);
      apb(1'b1, A_PRI, 32'h0);
      repeat (2) @(negedge clk);
      chk_val("module enables", 9'h1ff, mod_clk_en);
      chk_val("timer pins hold", 1'b0, timer_pins_hold);
      apb(1'b1, A_THI, 32'hff);
      apb(1'b0, A_THI, 32'h0);
      chk_val("third readback", 32'h81, rd);
      apb(1'b1, A_THI, 32'h0);
      for (int i = 0; i < 8; i++) begin
         s = 8'h01 << i;
         apb(1'b1, A_SEC, {24'h0, s});
         apb(1'b0, A_SEC, 32'h0);
         chk_val("secondary readback", {24'h0, s}, rd);
         chk_val("module enables", {~s[7], ~s[6], ~s[5], ~s[2], ~s[1], ~s[0], 3'b111},
                 mod_clk_en);
         chk_val("display flags", {s[4], s[3]},
                 {display_off, display_fetch_stop});
      end
      apb(1'b1, A_SEC, 32'h0);
      apb(1'b0, 32'h0, 32'h0);
      chk_val("unmapped error", 1'b1, er);
      chk_val("unmapped data", 32'h0, rd);
      $display("test registers done");
   endtask

   task automatic t_light();
      logic pr;
      logic pb;
      int n;
      apb(1'b1, A_THI, 32'h80);
      apb(1'b1, A_AUX, 32'h01);
      chk_val("bus clock normal", 1'b1, bus_controller_clk_en);
      refresh_en <= 1'b1;
      busy_en <= 1'b1;
      strobe(1'b1);
      chk_val("cpu halt", 1'b1, cpu_halt);
      chk_val("clock generator stop", 1'b0, clock_generator_stop);
      chk_val("module enables", 9'h1ff, mod_clk_en);
      chk_val("bus clock light", 1'b0, bus_controller_clk_en);
      apb(1'b0, A_AUX, 32'h0);
      chk_val("aux readback light", 32'h21, rd);
      n = 0;
      pr = refresh_active;
      pb = dma_xfer_busy | display_xfer_busy;
      repeat (32) begin
         @(negedge clk);
         status(~pr, 1'b0);
         chk_val("low power bus clock", pb, low_power_bus_controller_clk_en);
         n += int'(bus_clk_en);
         pr = refresh_active;
         pb = dma_xfer_busy | display_xfer_busy;
      end
      chk_val("quarter bus pulses", 32'd8, n);
      @(posedge clk);
      refresh_en <= 1'b0;
      busy_en <= 1'b0;
      strobe(1'b0);
      status(1'b0, 1'b0);
      chk_val("cpu halt", 1'b0, cpu_halt);
      chk_val("bus clock normal", 1'b1, bus_controller_clk_en);
      chk_val("bus clock steady", 1'b1, bus_clk_en);
      apb(1'b1, A_THI, 32'h0);
      apb(1'b1, A_AUX, 32'h0);
      $display("test light halt done");
   endtask

   task automatic t_deep();
      timer_from_calendar <= 1'b1;
      apb(1'b1, A_PRI, 32'h80);
      strobe(1'b1);
      strobe(1'b1);
      status(1'b0, 1'b1);
      chk_val("deep outputs", 4'hf, {cpu_halt, clock_generator_stop, self_refresh_req,
              ~bus_controller_clk_en});
      chk_val("module enables", 9'h004, mod_clk_en);
      strobe(1'b0);
      status(1'b0, 1'b0);
      chk_val("module enables", 9'h1ff, mod_clk_en);
      apb(1'b1, A_PRI, 32'h0);
      timer_from_calendar <= 1'b0;
      $display("test deep halt done");
   endtask

   task automatic t_wdt();
      int n;
      count32(1'b0, n);
      chk_val("watchdog own ticks", 32'd8, n);
      apb(1'b1, A_THI, 32'h01);
      repeat (2) @(negedge clk);
      count32(1'b0, n);
      chk_val("watchdog fixed ticks", 32'd32 / WDT_N, n);
      apb(1'b1, A_THI, 32'h0);
      $display("test watchdog done");
   endtask

   initial begin
      #1000000;
      err_count++;
      end_sim();
   end

   task automatic t_reset();
      repeat (2) @(negedge clk);
      status(1'b1, 1'b1);
      chk_val("module enables", 9'h1ff, mod_clk_en);
      repeat (18) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(negedge clk);
      status(1'b0, 1'b0);
      apb(1'b0, A_PRI, 32'h0);
      chk_val("primary reset", 32'h0, rd);
      apb(1'b0, A_SEC, 32'h0);
      chk_val("secondary reset", 32'h0, rd);
      $display("test reset done");
   endtask

   initial begin
      t_reset();
      t_regs();
      t_light();
      t_deep();
      t_wdt();
      end_sim();
   end
endmodule
